//--- rtl/psl_pkg.sv
// constants, types and decode functions for the reset and strap latch
package psl_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned RESET_MIN_NS  = 1000;
    localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 9;

    // ------------------------------------------------------------------
    // register map and responses
    // ------------------------------------------------------------------
    localparam int         AXI_AW       = 8;
    localparam logic [7:0] OFS_BMCR     = 8'h00;
    localparam logic [7:0] OFS_ANAR     = 8'h04;
    localparam logic [7:0] OFS_PHYCTL   = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    localparam int          BMCR_SPEED_BIT  = 13;
    localparam int          BMCR_ANEN_BIT   = 12;
    localparam int          BMCR_ISO_BIT    = 10;
    localparam int          BMCR_DUPLEX_BIT = 8;
    localparam logic [15:0] BMCR_WR_MASK    = 16'h3900;
    localparam int          ANAR_100FD_BIT  = 8;
    localparam int          ANAR_100HD_BIT  = 7;
    localparam int          ANAR_10FD_BIT   = 6;
    localparam int          ANAR_10HD_BIT   = 5;
    localparam logic [15:0] ANAR_SELECTOR   = 16'h0001;
    localparam logic [15:0] ANAR_WR_MASK    = 16'h01E0;
    localparam int          ADDR_W          = 5;
    localparam int          ST_ADV_LSB      = 5;
    localparam int          ST_ISO_BIT      = 7;
    localparam int          ST_RST_BIT      = 8;

    // ------------------------------------------------------------------
    // strap defaults given by the internal pulls
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_PULL = 5'h01;
    localparam logic [1:0] ADV_PULL  = 2'h3;
    localparam logic [4:0] ADDR_ZERO = 5'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ADV_10_ANY    = 2'b00,
        ADV_100_ANY   = 2'b01,
        ADV_HALF_ONLY = 2'b10,
        ADV_ALL       = 2'b11
    } psl_adv_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_PEND = 2'b01,
        ST_HOLD = 2'b10
    } psl_state_t;

    typedef enum logic [2:0] {
        SEL_BMCR   = 3'h0,
        SEL_ANAR   = 3'h1,
        SEL_PHYCTL = 3'h2,
        SEL_STATUS = 3'h3,
        SEL_NONE   = 3'h4
    } psl_sel_t;

    // ------------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------------
    function automatic logic [15:0] adv_to_anar(input logic [1:0] adv);
        logic [15:0] v;
        v = ANAR_SELECTOR;
        v[ANAR_10HD_BIT]  = (adv != ADV_100_ANY);
        v[ANAR_10FD_BIT]  = (adv == ADV_10_ANY) || (adv == ADV_ALL);
        v[ANAR_100HD_BIT] = (adv != ADV_10_ANY);
        v[ANAR_100FD_BIT] = (adv == ADV_100_ANY) || (adv == ADV_ALL);
        return v;
    endfunction : adv_to_anar

    function automatic logic [15:0] adv_to_bmcr(input logic [1:0] adv);
        logic [15:0] v;
        v = 16'h0000;
        v[BMCR_ANEN_BIT]   = 1'b1;
        v[BMCR_SPEED_BIT]  = (adv != ADV_10_ANY);
        v[BMCR_DUPLEX_BIT] = (adv != ADV_HALF_ONLY);
        return v;
    endfunction : adv_to_bmcr

endpackage : psl_pkg

//--- rtl/psl_reset_strap_latch.sv
// reset qualifier, strap latch, shared pin drive and register slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Contract
// [R1] The reset pin is active low, must be held low for at least 1 us, and then starts a full reset.
// [R2] Each hardware reset returns every register bit to its default value.
// [R3] Each hardware reset drops the old strap values and captures the pins afresh.
// [R4] Strap pins are sampled while reset is active and select the operating modes.
// [R5] Five address straps are captured into the five-bit address field of the control register.
// [R6] Any strapped address from zero to thirty-one is accepted.
// [R7] A strapped address of zero puts the device in MII isolate mode.
// [R8] Writing address zero through the registers never enters isolate mode.
// [R9] The two advertised-mode straps are loaded into the basic control and advertisement registers.
// [R10] After release the strap pins return to their output functions, so sampling ends before it.
// [R11] Advertised-mode straps default to 11 and decode to speed and duplex abilities.
// [R12] With no strap resistors the pulls give management address one.
// [R13] Latched strap values stay fixed until the next hardware reset.
module psl_reset_strap_latch #(
    parameter int unsigned RESET_MIN_CYC = psl_pkg::RESET_MIN_CYC
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        SRST_IN,
    input  wire logic        PHY_RESET_N_IN,
    input  wire logic        LINK_UP_IN,
    input  wire logic        SPEED_100_IN,
    input  wire logic        COLLISION_IN,
    input  wire logic [3:0]  RX_DATA_IN,
    input  wire logic        MGMT_ADDR_STRAP_BIT0_IN,
    input  wire logic [3:0]  MGMT_ADDR_STRAP_UPPER_IN,
    input  wire logic        ADV_MODE_STRAP_LOW_IN,
    input  wire logic        ADV_MODE_STRAP_HIGH_IN,
    output logic             COLLISION_OUT,
    output logic             COLLISION_OE_OUT,
    output logic [3:0]       RX_DATA_OUT,
    output logic             RX_DATA_OE_OUT,
    output logic             LINK_INDICATOR_OUT,
    output logic             LINK_INDICATOR_OE_OUT,
    output logic             SPEED_INDICATOR_OUT,
    output logic             SPEED_INDICATOR_OE_OUT,
    output logic [4:0]       MGMT_ADDR_PULL_OUT,
    output logic [1:0]       ADV_MODE_PULL_OUT,
    output logic [4:0]       PHY_ADDR_OUT,
    output logic             MII_ISOLATE_OUT,
    output logic             RESET_ACTIVE_OUT,
    output logic [15:0]      BMCR_OUT,
    output logic [15:0]      ANAR_OUT,
    input  wire logic [7:0]  S_AXI_AWADDR_IN,
    input  wire logic        S_AXI_AWVALID_IN,
    output logic             S_AXI_AWREADY_OUT,
    input  wire logic [31:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]  S_AXI_WSTRB_IN,
    input  wire logic        S_AXI_WVALID_IN,
    output logic             S_AXI_WREADY_OUT,
    output logic [1:0]       S_AXI_BRESP_OUT,
    output logic             S_AXI_BVALID_OUT,
    input  wire logic        S_AXI_BREADY_IN,
    input  wire logic [7:0]  S_AXI_ARADDR_IN,
    input  wire logic        S_AXI_ARVALID_IN,
    output logic             S_AXI_ARREADY_OUT,
    output logic [31:0]      S_AXI_RDATA_OUT,
    output logic [1:0]       S_AXI_RRESP_OUT,
    output logic             S_AXI_RVALID_OUT,
    input  wire logic        S_AXI_RREADY_IN
);

    // --------
    // declarations
    // --------
    psl_pkg::psl_state_t state_r;
    psl_pkg::psl_state_t state_nxt;
    logic [psl_pkg::CNT_W-1:0] low_cnt_r;
    logic                hold;
    logic                commit;
    logic [4:0]          samp_addr;
    logic [1:0]          samp_adv;
    logic [4:0]          lat_addr;
    logic [1:0]          lat_adv;
    logic                lat_iso;
    logic [15:0]         bmcr_r;
    logic [15:0]         anar_r;
    logic [4:0]          phy_addr_r;
    logic                aw_full_r;
    logic                w_full_r;
    logic [7:0]          aw_addr_r;
    logic [31:0]         w_data_r;
    logic [3:0]          w_strb_r;
    logic                wr_fire;
    logic                wr_ok;
    psl_pkg::psl_sel_t   wr_sel;
    psl_pkg::psl_sel_t   rd_sel;
    logic [15:0]         rd_val;

    // --------
    // helpers
    // --------
    function automatic psl_pkg::psl_sel_t reg_sel(input logic [7:0] addr);
        psl_pkg::psl_sel_t s;
        unique case (addr)
            psl_pkg::OFS_BMCR:   s = psl_pkg::SEL_BMCR;
            psl_pkg::OFS_ANAR:   s = psl_pkg::SEL_ANAR;
            psl_pkg::OFS_PHYCTL: s = psl_pkg::SEL_PHYCTL;
            psl_pkg::OFS_STATUS: s = psl_pkg::SEL_STATUS;
            default:             s = psl_pkg::SEL_NONE;
        endcase
        return s;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        for (int i = 0; i < 2; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = (old[i*8 +: 8] & ~mask[i*8 +: 8])
                            | (data[i*8 +: 8] & mask[i*8 +: 8]);
            end
        end
        return v;
    endfunction : merge16

    // --------
    // reset pin qualifier
    // --------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            psl_pkg::ST_RUN: begin
                if (!PHY_RESET_N_IN) begin
                    state_nxt = psl_pkg::ST_PEND;
                end
            end
            psl_pkg::ST_PEND: begin
                if (PHY_RESET_N_IN) begin
                    state_nxt = psl_pkg::ST_RUN;
                end else if (32'(low_cnt_r) >= RESET_MIN_CYC - 1) begin
                    state_nxt = psl_pkg::ST_HOLD; // R1
                end
            end
            psl_pkg::ST_HOLD: begin
                if (PHY_RESET_N_IN) begin
                    state_nxt = psl_pkg::ST_RUN; // R10
                end
            end
            default: state_nxt = psl_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            state_r <= psl_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // low-time counter, saturating at the limit
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN || PHY_RESET_N_IN) begin
            low_cnt_r <= '0;
        end else if (32'(low_cnt_r) < RESET_MIN_CYC) begin
            low_cnt_r <= low_cnt_r + 1'b1; // R1
        end
    end

    assign hold   = (state_r == psl_pkg::ST_HOLD);
    assign commit = hold && PHY_RESET_N_IN; // R10

    // --------
    // strap capture
    // --------
    psl_strap_capture u_capture (
        .clk_in        (REF_CLK_IN),
        .srst_in       (SRST_IN),
        .sample_in     (hold),
        .commit_in     (commit),
        .addr_pin_in   ({MGMT_ADDR_STRAP_UPPER_IN, MGMT_ADDR_STRAP_BIT0_IN}),
        .adv_pin_in    ({ADV_MODE_STRAP_HIGH_IN, ADV_MODE_STRAP_LOW_IN}),
        .samp_addr_out (samp_addr),
        .samp_adv_out  (samp_adv),
        .addr_out      (lat_addr),
        .adv_out       (lat_adv),
        .isolate_out   (lat_iso)
    );

    // --------
    // shared pin drive
    // --------
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            COLLISION_OUT       <= 1'b0;
            RX_DATA_OUT         <= 4'h0;
            LINK_INDICATOR_OUT  <= 1'b0;
            SPEED_INDICATOR_OUT <= 1'b0;
        end else begin
            COLLISION_OUT       <= COLLISION_IN;
            RX_DATA_OUT         <= RX_DATA_IN;
            LINK_INDICATOR_OUT  <= LINK_UP_IN;
            SPEED_INDICATOR_OUT <= SPEED_100_IN;
        end
    end

    // weak pulls, for the board wire to resolve when nothing else drives
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            MGMT_ADDR_PULL_OUT <= psl_pkg::ADDR_PULL; // R12
            ADV_MODE_PULL_OUT  <= psl_pkg::ADV_PULL; // R11
        end else begin
            MGMT_ADDR_PULL_OUT <= psl_pkg::ADDR_PULL;
            ADV_MODE_PULL_OUT  <= psl_pkg::ADV_PULL;
        end
    end

    assign LINK_INDICATOR_OE_OUT  = !hold; // R10
    assign SPEED_INDICATOR_OE_OUT = !hold; // R10
    assign COLLISION_OE_OUT       = !hold && !lat_iso; // R7
    assign RX_DATA_OE_OUT         = !hold && !lat_iso; // R7

    // --------
    // register slave, write channel
    // --------
    assign S_AXI_AWREADY_OUT = !aw_full_r && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT  = !w_full_r && !S_AXI_BVALID_OUT;
    assign wr_fire           = aw_full_r && w_full_r && !S_AXI_BVALID_OUT;
    assign wr_sel            = reg_sel(aw_addr_r);
    assign wr_ok             = wr_fire && !hold && (wr_sel != psl_pkg::SEL_NONE)
                             && (wr_sel != psl_pkg::SEL_STATUS);

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR_IN;
        end else if (wr_fire) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_full_r <= 1'b1;
            w_data_r <= S_AXI_WDATA_IN;
            w_strb_r <= S_AXI_WSTRB_IN;
        end else if (wr_fire) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT  <= psl_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= wr_ok ? psl_pkg::RESP_OKAY : psl_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end

    // --------
    // registers
    // --------
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            bmcr_r <= psl_pkg::adv_to_bmcr(psl_pkg::ADV_PULL); // R2
        end else if (hold) begin
            bmcr_r <= psl_pkg::adv_to_bmcr(samp_adv); // R9
        end else if (wr_ok && wr_sel == psl_pkg::SEL_BMCR) begin
            bmcr_r <= merge16(bmcr_r, w_data_r, w_strb_r, psl_pkg::BMCR_WR_MASK);
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            anar_r <= psl_pkg::adv_to_anar(psl_pkg::ADV_PULL); // R2
        end else if (hold) begin
            anar_r <= psl_pkg::adv_to_anar(samp_adv); // R9
        end else if (wr_ok && wr_sel == psl_pkg::SEL_ANAR) begin
            anar_r <= merge16(anar_r, w_data_r, w_strb_r, psl_pkg::ANAR_WR_MASK);
        end
    end

    // address field is writable, but isolate follows only the strap
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            phy_addr_r <= psl_pkg::ADDR_PULL; // R2
        end else if (hold) begin
            phy_addr_r <= samp_addr; // R5 R6
        end else if (wr_ok && wr_sel == psl_pkg::SEL_PHYCTL && w_strb_r[0]) begin
            phy_addr_r <= w_data_r[psl_pkg::ADDR_W-1:0]; // R8
        end
    end

    // --------
    // register slave, read channel
    // --------
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    assign rd_sel            = reg_sel(S_AXI_ARADDR_IN);

    always_comb begin
        rd_val = 16'h0000;
        unique case (rd_sel)
            psl_pkg::SEL_BMCR: begin
                rd_val = bmcr_r;
                rd_val[psl_pkg::BMCR_ISO_BIT] = lat_iso; // R8
            end
            psl_pkg::SEL_ANAR:   rd_val = anar_r;
            psl_pkg::SEL_PHYCTL: rd_val = {11'h000, phy_addr_r};
            psl_pkg::SEL_STATUS: begin
                rd_val[psl_pkg::ADDR_W-1:0]              = lat_addr; // R13
                rd_val[psl_pkg::ST_ADV_LSB +: 2]         = lat_adv; // R13
                rd_val[psl_pkg::ST_ISO_BIT]              = lat_iso;
                rd_val[psl_pkg::ST_RST_BIT]              = hold;
            end
            psl_pkg::SEL_NONE:   rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT  <= 32'h0000_0000;
            S_AXI_RRESP_OUT  <= psl_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT  <= {16'h0000, rd_val};
            S_AXI_RRESP_OUT  <= (rd_sel == psl_pkg::SEL_NONE) ? psl_pkg::RESP_SLVERR
                                                              : psl_pkg::RESP_OKAY;
        end else if (S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end

    // --------
    // status outputs
    // --------
    assign PHY_ADDR_OUT     = phy_addr_r;
    assign MII_ISOLATE_OUT  = lat_iso; // R7
    assign RESET_ACTIVE_OUT = hold;
    assign BMCR_OUT         = bmcr_r;
    assign ANAR_OUT         = anar_r;

endmodule : psl_reset_strap_latch

//--- rtl/psl_strap_capture.sv
// strap sampling during reset and latching at its release
`timescale 1ns/1ps
module psl_strap_capture (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       sample_in,
    input  wire logic       commit_in,
    input  wire logic [4:0] addr_pin_in,
    input  wire logic [1:0] adv_pin_in,
    output logic      [4:0] samp_addr_out,
    output logic      [1:0] samp_adv_out,
    output logic      [4:0] addr_out,
    output logic      [1:0] adv_out,
    output logic            isolate_out
);

    // ------------------------------------------------------------------
    // sample while reset is held, pins not driven
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            samp_addr_out <= psl_pkg::ADDR_PULL;
            samp_adv_out  <= psl_pkg::ADV_PULL;
        end else if (sample_in) begin
            samp_addr_out <= addr_pin_in; // R4
            samp_adv_out  <= adv_pin_in; // R4
        end
    end

    // ------------------------------------------------------------------
    // latch at release, hold until the next reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            addr_out    <= psl_pkg::ADDR_PULL; // R12
            adv_out     <= psl_pkg::ADV_PULL; // R11
            isolate_out <= (psl_pkg::ADDR_PULL == psl_pkg::ADDR_ZERO);
        end else if (commit_in) begin
            addr_out    <= samp_addr_out; // R3
            adv_out     <= samp_adv_out; // R3
            isolate_out <= (samp_addr_out == psl_pkg::ADDR_ZERO); // R7
        end
    end

endmodule : psl_strap_capture

//--- tb/psl_board.sv
// board side: strap resistors and internal pulls resolving the shared pins
`timescale 1ns/1ps
module psl_board (
    input  wire logic [6:0] dev_in,
    input  wire logic [6:0] oe_in,
    input  wire logic [6:0] pull_in,
    input  wire logic [6:0] fit_in,
    input  wire logic [6:0] res_in,
    output logic      [6:0] pin_out
);
    // resistors are weak: a driving device always wins, never a rail tie
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pin_out[i] = oe_in[i] ? dev_in[i] : (fit_in[i] ? res_in[i] : pull_in[i]);
        end
    end
endmodule : psl_board

//--- tb/psl_props.sv
// concurrent checks on the reset and strap latch ports
`timescale 1ns/1ps
module psl_props #(
    parameter int unsigned RESET_MIN_CYC = 250
) (
    input wire logic       REF_CLK_IN,
    input wire logic       SRST_IN,
    input wire logic       PHY_RESET_N_IN,
    input wire logic       COLLISION_OE_OUT,
    input wire logic       LINK_INDICATOR_OE_OUT,
    input wire logic [4:0] PHY_ADDR_OUT,
    input wire logic       MII_ISOLATE_OUT,
    input wire logic       RESET_ACTIVE_OUT,
    input wire logic [4:0] MGMT_ADDR_PULL_OUT,
    input wire logic       S_AXI_ARVALID_IN,
    input wire logic       S_AXI_ARREADY_OUT,
    input wire logic       S_AXI_RVALID_OUT
);
    // --------
    // consecutive low samples of the reset pin
    // --------
    int unsigned lo_cnt_r;
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN || PHY_RESET_N_IN) lo_cnt_r <= 0;
        else if (lo_cnt_r < 1000) lo_cnt_r <= lo_cnt_r + 1;
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);
    // --------
    // properties
    // --------
    a_hold_pins_off: assert property (RESET_ACTIVE_OUT |-> !COLLISION_OE_OUT && !LINK_INDICATOR_OE_OUT)
        else $error("shared pins driven during reset hold");
    a_run_pins_on: assert property ($fell(RESET_ACTIVE_OUT) |-> LINK_INDICATOR_OE_OUT)
        else $error("indicator pin not driven after release");
    a_iso_mii_off: assert property (MII_ISOLATE_OUT |-> !COLLISION_OE_OUT)
        else $error("mii pin driven while isolated");
    a_iso_from_strap: assert property ($fell(RESET_ACTIVE_OUT) |-> MII_ISOLATE_OUT == (PHY_ADDR_OUT == 5'h00))
        else $error("isolate does not match latched address");
    a_iso_stays_put: assert property (!RESET_ACTIVE_OUT && !$past(RESET_ACTIVE_OUT) |-> $stable(MII_ISOLATE_OUT))
        else $error("isolate changed outside reset");
    a_short_ignored: assert property ($rose(RESET_ACTIVE_OUT) |-> lo_cnt_r >= RESET_MIN_CYC)
        else $error("short pulse taken");
    a_long_low_hold: assert property (lo_cnt_r >= RESET_MIN_CYC |-> RESET_ACTIVE_OUT)
        else $error("long reset pulse not taken");
    a_pull_default: assert property (MGMT_ADDR_PULL_OUT == 5'h01)
        else $error("address pull levels wrong");
    a_read_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read answer missing");
    c_iso_release: cover property ($fell(RESET_ACTIVE_OUT) && MII_ISOLATE_OUT);
    c_hold_entry: cover property ($rose(RESET_ACTIVE_OUT));
    c_read_data: cover property (S_AXI_RVALID_OUT);
endmodule : psl_props

bind psl_reset_strap_latch psl_props #(.RESET_MIN_CYC(RESET_MIN_CYC)) u_psl_props (.*);

//--- tb/tb_top.sv
// self-checking bench for the reset and strap latch
`timescale 1ns/1ps
module tb_top;
    localparam int MC = 4;
    logic REF_CLK_IN, SRST_IN, PHY_RESET_N_IN, LINK_UP_IN, SPEED_100_IN, COLLISION_IN;
    logic [3:0] RX_DATA_IN, RX_DATA_OUT, MGMT_ADDR_STRAP_UPPER_IN, S_AXI_WSTRB_IN;
    logic MGMT_ADDR_STRAP_BIT0_IN, ADV_MODE_STRAP_LOW_IN, ADV_MODE_STRAP_HIGH_IN, COLLISION_OUT;
    logic COLLISION_OE_OUT, RX_DATA_OE_OUT, LINK_INDICATOR_OUT, LINK_INDICATOR_OE_OUT;
    logic SPEED_INDICATOR_OUT, SPEED_INDICATOR_OE_OUT, MII_ISOLATE_OUT, RESET_ACTIVE_OUT;
    logic [4:0] MGMT_ADDR_PULL_OUT, PHY_ADDR_OUT;
    logic [1:0] ADV_MODE_PULL_OUT, S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
    logic [15:0] BMCR_OUT, ANAR_OUT;
    logic [7:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
    logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT;
    logic S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT;
    logic S_AXI_BREADY_IN, S_AXI_ARVALID_IN, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN;
    logic [6:0] fit, res, pin;
    int checks, mismatches;
    logic [15:0] anar_t [4] = '{16'h0061, 16'h0181, 16'h00A1, 16'h01E1};
    logic [15:0] bmcr_t [4] = '{16'h1100, 16'h3100, 16'h3000, 16'h3100};
    psl_reset_strap_latch #(.RESET_MIN_CYC(MC)) u_psl_reset_strap_latch (.*);
    psl_board u_psl_board (
        .dev_in({SPEED_INDICATOR_OUT, LINK_INDICATOR_OUT, RX_DATA_OUT, COLLISION_OUT}),
        .oe_in({SPEED_INDICATOR_OE_OUT, LINK_INDICATOR_OE_OUT, {4{RX_DATA_OE_OUT}}, COLLISION_OE_OUT}),
        .pull_in({ADV_MODE_PULL_OUT, MGMT_ADDR_PULL_OUT}), .fit_in(fit), .res_in(res), .pin_out(pin));
    assign {ADV_MODE_STRAP_HIGH_IN, ADV_MODE_STRAP_LOW_IN} = pin[6:5];
    assign {MGMT_ADDR_STRAP_UPPER_IN, MGMT_ADDR_STRAP_BIT0_IN} = pin[4:0];
    always #2 REF_CLK_IN = ~REF_CLK_IN;
    // --------
    // tasks
    // --------
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one bus access; for reads d is the expected data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int t;
        t = 0;
        if (w) begin
            S_AXI_AWADDR_IN <= a; S_AXI_WDATA_IN <= d; S_AXI_AWVALID_IN <= 1; S_AXI_WVALID_IN <= 1;
            S_AXI_BREADY_IN <= 1;
        end else begin
            S_AXI_ARADDR_IN <= a; S_AXI_ARVALID_IN <= 1; S_AXI_RREADY_IN <= 1;
        end
        do begin
            @(posedge REF_CLK_IN);
            t++;
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT === 1'b1) S_AXI_AWVALID_IN <= 0;
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT === 1'b1) S_AXI_WVALID_IN <= 0;
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT === 1'b1) S_AXI_ARVALID_IN <= 0;
        end while (!(w ? S_AXI_BVALID_OUT === 1'b1 : S_AXI_RVALID_OUT === 1'b1) && t < 40);
        if (t >= 40) begin
            mismatches++;
            end_of_test();
        end
        if (w) chk(S_AXI_BRESP_OUT, r);
        else begin
            chk(S_AXI_RDATA_OUT, d);
            chk(S_AXI_RRESP_OUT, r);
        end
        S_AXI_BREADY_IN <= 0; S_AXI_RREADY_IN <= 0;
        @(posedge REF_CLK_IN);
    endtask : acc
    // pin low for n cycles with straps {m,a} fitted
    task automatic hw_rst(input logic [4:0] a, input logic [1:0] m, input int n);
        fit <= 7'h7F; res <= {m, a}; PHY_RESET_N_IN <= 0;
        repeat (n) @(posedge REF_CLK_IN);
        chk(RESET_ACTIVE_OUT, n >= MC);
        PHY_RESET_N_IN <= 1;
        repeat (4) @(posedge REF_CLK_IN);
    endtask : hw_rst
    // --------
    // main sequence
    // --------
    initial begin
        REF_CLK_IN = 0; SRST_IN = 1; PHY_RESET_N_IN = 1; LINK_UP_IN = 0; SPEED_100_IN = 0;
        COLLISION_IN = 0; RX_DATA_IN = 0; S_AXI_WSTRB_IN = 4'hF; S_AXI_AWADDR_IN = 0;
        S_AXI_ARADDR_IN = 0; S_AXI_WDATA_IN = 0; S_AXI_AWVALID_IN = 0; S_AXI_WVALID_IN = 0;
        S_AXI_BREADY_IN = 0; S_AXI_ARVALID_IN = 0; S_AXI_RREADY_IN = 0; fit = 0; res = 0;
        repeat (10) @(posedge REF_CLK_IN);
        SRST_IN <= 0;
        repeat (3) @(posedge REF_CLK_IN);
        acc(0, 8'h08, 32'h01, 2'h0);
        acc(0, 8'h04, 32'h1E1, 2'h0);
        acc(0, 8'h0C, 32'h61, 2'h0);
        $display("defaults done");
        for (int m = 0; m < 4; m++) begin
            hw_rst(5'h1F, m[1:0], MC + 4);
            acc(0, 8'h04, anar_t[m], 2'h0);
            acc(0, 8'h00, bmcr_t[m], 2'h0);
            acc(0, 8'h0C, {25'h0, m[1:0], 5'h1F}, 2'h0);
        end
        $display("modes done");
        hw_rst(5'h00, 2'h3, MC + 4);
        chk(MII_ISOLATE_OUT, 1);
        chk(COLLISION_OE_OUT, 0);
        acc(0, 8'h00, 32'h3500, 2'h0);
        hw_rst(5'h05, 2'h3, MC + 4);
        acc(1, 8'h08, 32'h0, 2'h0);
        acc(1, 8'h04, 32'h0, 2'h0);
        acc(1, 8'h00, 32'h0, 2'h0);
        chk(MII_ISOLATE_OUT, 0);
        acc(0, 8'h08, 32'h0, 2'h0);
        res <= 7'h00; LINK_UP_IN <= 1; RX_DATA_IN <= 4'hF; COLLISION_IN <= 1;
        repeat (20) @(posedge REF_CLK_IN);
        acc(0, 8'h0C, 32'h65, 2'h0);
        chk({BMCR_OUT, ANAR_OUT}, 32'h0000_0001);
        chk({ADV_MODE_PULL_OUT, LINK_INDICATOR_OUT, SPEED_INDICATOR_OUT, RX_DATA_OUT}, 32'hEF);
        chk({COLLISION_OUT, RX_DATA_OE_OUT, SPEED_INDICATOR_OE_OUT}, 32'h7);
        $display("isolate done");
        hw_rst(5'h0A, 2'h1, MC + 4);
        acc(0, 8'h08, 32'h0A, 2'h0);
        acc(0, 8'h04, 32'h181, 2'h0);
        acc(0, 8'h00, 32'h3100, 2'h0);
        hw_rst(5'h00, 2'h0, MC - 2);
        acc(0, 8'h0C, 32'h2A, 2'h0);
        acc(0, 8'h10, 32'h0, 2'h2);
        acc(1, 8'h0C, 32'hFF, 2'h2);
        $display("rereset done");
        end_of_test();
    end
endmodule : tb_top
